// *** hdl/slc_pkg.sv ***
// constants and types shared by the segment display controller
// -----------------------------------------------------------------------------
// What this block does
// - at most 8 backplane and 40 frontplane lines; eighth duty leaves 36 lines.
// - duty field picks static, 1/2, 1/3, 1/4, 1/6 or 1/8 multiplexing.
// - bias field picks static, 1/2 or 1/3; waveform uses matching levels.
// - internal divider: contrast 0..15, zero is full supply, higher is lower.
// - clock comes from internal slow oscillator or external slow crystal.
// - DMA requests issued by software or by the frame event.
// - when active, interrupt after one more than a software-set count of completed frames.
// - layout zero: all backplane phases of one frontplane line in one byte.
// - layout one: several frontplane lines of one phase share one byte.
// - display store holds sixteen software-writable words selecting lit pixels.
// - blink periodically blanks and restores display at selectable rate.
// - waveforms alternate polarity within each frame, net zero DC.
// - display keeps refreshing in run, sleep and stop states.
// - unused frontplane and backplane pins can be released to other uses.
// - internal divider circuitry follows configured bias and duty.
// - layout one eighth duty: words 0-7 lines 0-31, words 8-15 lines 32-35.
// -----------------------------------------------------------------------------
package slc_pkg;
    localparam int NUM_BP        = 8;
    localparam int NUM_FP        = 40;
    localparam int NUM_WORDS     = 16;
    localparam int WORD_W        = 32;
    localparam int BYTE_W        = 8;
    localparam int BYTES_PER_WD  = 4;

    localparam logic [5:0] FP_USED_EIGHTH = 6'h24;
    localparam logic [5:0] FP_USED_OTHER  = 6'h28;
    localparam logic [3:0] HI_WORD_BASE   = 4'h8;
    localparam int         BLINK_BASE_BIT = 2;

    // drive levels in sixths of the panel voltage
    localparam logic [2:0] LVL_GND      = 3'h0;
    localparam logic [2:0] LVL_THIRD_LO = 3'h2;
    localparam logic [2:0] LVL_HALF     = 3'h3;
    localparam logic [2:0] LVL_THIRD_HI = 3'h4;
    localparam logic [2:0] LVL_TOP      = 3'h6;

    localparam logic [3:0] CONTRAST_FULL = 4'h0;

    typedef enum logic [2:0] {
        SLC_DUTY_STATIC  = 3'h0,
        SLC_DUTY_HALF    = 3'h1,
        SLC_DUTY_THIRD   = 3'h2,
        SLC_DUTY_QUARTER = 3'h3,
        SLC_DUTY_SIXTH   = 3'h4,
        SLC_DUTY_EIGHTH  = 3'h5
    } slc_duty_t;

    typedef enum logic [1:0] {
        SLC_BIAS_STATIC = 2'h0,
        SLC_BIAS_HALF   = 2'h1,
        SLC_BIAS_THIRD  = 2'h2
    } slc_bias_t;

    // ladder taps needed beside ground and top
    localparam logic [1:0] TAPS_STATIC = 2'h0;
    localparam logic [1:0] TAPS_HALF   = 2'h1;
    localparam logic [1:0] TAPS_THIRD  = 2'h2;

    typedef enum logic [1:0] {
        SLC_ST_OFF = 2'b00,
        SLC_ST_POS = 2'b01,
        SLC_ST_NEG = 2'b11
    } slc_state_t;

    // backplane lines scanned per duty; undefined codes fall back to static
    function automatic logic [3:0] slc_duty_lines(input logic [2:0] duty);
        case (duty)
            SLC_DUTY_HALF:    slc_duty_lines = 4'h2;
            SLC_DUTY_THIRD:   slc_duty_lines = 4'h3;
            SLC_DUTY_QUARTER: slc_duty_lines = 4'h4;
            SLC_DUTY_SIXTH:   slc_duty_lines = 4'h6;
            SLC_DUTY_EIGHTH:  slc_duty_lines = 4'h8;
            default:          slc_duty_lines = 4'h1;
        endcase
    endfunction
endpackage

// *** hdl/slc_pixel_map.sv ***
// pixel bit lookup for the current backplane phase, both store layouts
`timescale 1ns/1ps
`default_nettype none
module slc_pixel_map (
    // store and selection
    input  wire logic [slc_pkg::NUM_WORDS-1:0][slc_pkg::WORD_W-1:0] store,
    input  wire logic                                               layout,
    input  wire logic [2:0]                                         phase,
    // pixel bits, one per frontplane line
    output logic      [slc_pkg::NUM_FP-1:0]                         pix
);
    import slc_pkg::*;

    genvar i;
    generate
        for (i = 0; i < NUM_FP; i++) begin : g_fp
            logic [BYTE_W-1:0] own_byte;
            logic              row_bit;
            // layout zero: line i owns one byte, bit = phase
            assign own_byte = store[i / BYTES_PER_WD][(i % BYTES_PER_WD) * BYTE_W +: BYTE_W];
            if (i < WORD_W) begin : g_lo
                assign row_bit = store[{1'b0, phase}][i];
            end else begin : g_hi
                assign row_bit = store[HI_WORD_BASE + {1'b0, phase}][i - WORD_W];
            end
            assign pix[i] = layout ? row_bit : own_byte[phase];
        end
    endgenerate
endmodule
`default_nettype wire

// *** hdl/slc_core.sv ***
// segment display controller: scan timing, waveform levels, store, events
`timescale 1ns/1ps
`default_nettype none
module slc_core (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    // slow clock ticks, one-cycle pulses
    input  wire logic                          internal_slow_osc_tick,
    input  wire logic                          external_slow_crystal_tick,
    input  wire logic                          clk_src_sel,
    // configuration
    input  wire logic                          enable,
    input  wire logic [2:0]                    duty,
    input  wire logic [1:0]                    bias,
    input  wire logic                          layout,
    input  wire logic                          int_divider_sel,
    input  wire logic [3:0]                    contrast,
    input  wire logic [15:0]                   half_slot_ticks,
    input  wire logic                          blink_en,
    input  wire logic [1:0]                    blink_rate,
    input  wire logic                          frame_irq_en,
    input  wire logic [3:0]                    frame_irq_count,
    input  wire logic                          frame_flag_clr,
    input  wire logic                          dma_sw_req,
    input  wire logic                          dma_hw_en,
    input  wire logic [slc_pkg::NUM_FP-1:0]    fp_release,
    input  wire logic [slc_pkg::NUM_BP-1:0]    bp_release,
    // display store write port
    input  wire logic                          store_wr,
    input  wire logic [3:0]                    store_addr,
    input  wire logic [slc_pkg::WORD_W-1:0]    store_wdata,
    // panel drive, 3 bits per line in sixths of panel voltage
    output logic      [3*slc_pkg::NUM_BP-1:0]  backplane_line,
    output logic      [3*slc_pkg::NUM_FP-1:0]  frontplane_line,
    output logic      [slc_pkg::NUM_BP-1:0]    backplane_oe,
    output logic      [slc_pkg::NUM_FP-1:0]    frontplane_oe,
    // divider control
    output logic                               ladder_en,
    output logic      [1:0]                    ladder_taps,
    output logic      [3:0]                    contrast_tap,
    // events
    output logic                               frame_flag,
    output logic                               dma_req,
    output logic                               frame_start
);
    import slc_pkg::*;

    // -------------------------------------------------------------------------
    // scan state
    // -------------------------------------------------------------------------
    slc_state_t st;
    slc_state_t next_st;
    logic [2:0]  slot;
    logic [2:0]  next_slot;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [3:0]  frame_cnt;
    logic [3:0]  next_frame_cnt;
    logic [5:0]  blink_cnt;
    logic [5:0]  next_blink_cnt;
    logic        next_frame_flag;
    logic        next_dma_req;
    logic        next_frame_start;
    logic        load_active;
    logic        tick;
    logic        half_done;
    logic        frame_end;
    logic        irq_hit;
    logic [3:0]  n_bp;
    logic [2:0]  last_slot;

    // clock source choice, both ticks keep running in low-power states
    assign tick      = clk_src_sel ? external_slow_crystal_tick
                                   : internal_slow_osc_tick;
    assign half_done = tick && (div_cnt == half_slot_ticks);
    assign n_bp      = slc_duty_lines(duty);
    assign last_slot = 3'(n_bp - 4'h1);

    always_comb begin
        next_st          = st;
        next_slot        = slot;
        next_div_cnt     = div_cnt;
        next_frame_cnt   = frame_cnt;
        next_blink_cnt   = blink_cnt;
        load_active      = 1'b0;
        frame_end        = 1'b0;
        next_frame_start = 1'b0;
        irq_hit          = 1'b0;
        unique case (st)
            SLC_ST_OFF: begin
                if (enable) begin
                    next_st          = SLC_ST_POS;
                    next_slot        = 3'h0;
                    next_div_cnt     = 16'h0000;
                    load_active      = 1'b1;
                    next_frame_start = 1'b1;
                end
            end
            SLC_ST_POS: begin
                if (!enable) begin
                    next_st = SLC_ST_OFF;
                end else if (half_done) begin
                    next_div_cnt = 16'h0000;
                    next_st      = SLC_ST_NEG;
                end else if (tick) begin
                    next_div_cnt = div_cnt + 16'h0001;
                end
            end
            SLC_ST_NEG: begin
                if (!enable) begin
                    next_st = SLC_ST_OFF;
                end else if (half_done) begin
                    next_div_cnt = 16'h0000;
                    next_st      = SLC_ST_POS;
                    if (slot >= last_slot) begin
                        // one slot per active backplane line per frame
                        next_slot        = 3'h0;
                        frame_end        = 1'b1;
                        load_active      = 1'b1;
                        next_frame_start = 1'b1;
                        next_blink_cnt   = blink_cnt + 6'h01;
                        if (frame_cnt == frame_irq_count) begin
                            next_frame_cnt = 4'h0;
                            irq_hit        = 1'b1;
                        end else begin
                            next_frame_cnt = frame_cnt + 4'h1;
                        end
                    end else begin
                        next_slot = slot + 3'h1;
                    end
                end else if (tick) begin
                    next_div_cnt = div_cnt + 16'h0001;
                end
            end
            default: begin
                next_st = SLC_ST_OFF;
            end
        endcase
        // a new count of frames begins each time the block is enabled
        if (st == SLC_ST_OFF) begin
            next_frame_cnt = 4'h0;
        end
        // set wins over a clear in the same cycle
        next_frame_flag = (frame_flag && !frame_flag_clr) || (irq_hit && frame_irq_en);
        next_dma_req    = dma_sw_req || (frame_end && dma_hw_en);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st          <= SLC_ST_OFF;
            slot        <= 3'h0;
            div_cnt     <= 16'h0000;
            frame_cnt   <= 4'h0;
            blink_cnt   <= 6'h00;
            frame_flag  <= 1'b0;
            dma_req     <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            st          <= next_st;
            slot        <= next_slot;
            div_cnt     <= next_div_cnt;
            frame_cnt   <= next_frame_cnt;
            blink_cnt   <= next_blink_cnt;
            frame_flag  <= next_frame_flag;
            dma_req     <= next_dma_req;
            frame_start <= next_frame_start;
        end
    end

    // -------------------------------------------------------------------------
    // display store: shadow takes writes, active copy swaps at frame edge
    // -------------------------------------------------------------------------
    logic [NUM_WORDS-1:0][WORD_W-1:0] shadow;
    logic [NUM_WORDS-1:0][WORD_W-1:0] next_shadow;
    logic [NUM_WORDS-1:0][WORD_W-1:0] active;
    logic [NUM_WORDS-1:0][WORD_W-1:0] next_active;

    always_comb begin
        next_shadow = shadow;
        next_active = active;
        if (store_wr) begin
            next_shadow[store_addr] = store_wdata;
        end
        // a write in the swap cycle lands one frame later, never mid-frame
        if (load_active) begin
            next_active = shadow;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shadow <= '0;
            active <= '0;
        end else begin
            shadow <= next_shadow;
            active <= next_active;
        end
    end

    logic [NUM_FP-1:0] pix;

    slc_pixel_map u_map (
        .store  (active),
        .layout (layout),
        .phase  (slot),
        .pix    (pix)
    );

    // -------------------------------------------------------------------------
    // waveform levels per line
    // -------------------------------------------------------------------------
    logic                      blank;
    logic                      is_third;
    logic                      is_neg;
    logic                      running;
    logic [5:0]                fp_used;
    logic [2:0]                bp_unsel;
    logic [2:0]                fp_off;
    logic [3*NUM_BP-1:0]       next_backplane_line;
    logic [3*NUM_FP-1:0]       next_frontplane_line;
    logic [NUM_BP-1:0]         next_backplane_oe;
    logic [NUM_FP-1:0]         next_frontplane_oe;

    assign blank    = blink_en && blink_cnt[BLINK_BASE_BIT + int'(blink_rate)];
    assign is_third = (bias == SLC_BIAS_THIRD);
    assign is_neg   = (st == SLC_ST_NEG);
    assign running  = (st != SLC_ST_OFF);
    assign fp_used  = (duty == SLC_DUTY_EIGHTH) ? FP_USED_EIGHTH : FP_USED_OTHER;
    assign bp_unsel = is_third ? LVL_THIRD_LO : LVL_HALF;
    assign fp_off   = is_third ? LVL_THIRD_HI : LVL_TOP;

    genvar j;
    generate
        for (j = 0; j < NUM_BP; j++) begin : g_bp
            logic [2:0] pos_lvl;
            assign pos_lvl = (slot == 3'(j)) ? LVL_TOP : bp_unsel;
            // negative half mirrors the positive one, so DC cancels
            assign next_backplane_line[3*j +: 3] = !running ? LVL_GND
                                             : is_neg ? (LVL_TOP - pos_lvl) : pos_lvl;
            assign next_backplane_oe[j] = running && !bp_release[j]
                                          && (4'(j) < n_bp);
        end
        for (j = 0; j < NUM_FP; j++) begin : g_fp
            logic [2:0] pos_lvl;
            assign pos_lvl = (pix[j] && !blank) ? LVL_GND : fp_off;
            assign next_frontplane_line[3*j +: 3] = !running ? LVL_GND
                                              : is_neg ? (LVL_TOP - pos_lvl) : pos_lvl;
            assign next_frontplane_oe[j] = running && !fp_release[j]
                                           && (6'(j) < fp_used);
        end
    endgenerate

    // -------------------------------------------------------------------------
    // divider control
    // -------------------------------------------------------------------------
    logic       next_ladder_en;
    logic [1:0] next_ladder_taps;
    logic [3:0] next_contrast_tap;

    always_comb begin
        next_ladder_en    = running && int_divider_sel;
        next_contrast_tap = int_divider_sel ? contrast : CONTRAST_FULL;
        next_ladder_taps  = TAPS_STATIC;
        if (int_divider_sel) begin
            // taps follow bias; static duty needs none whatever the bias
            if (duty == SLC_DUTY_STATIC || duty > SLC_DUTY_EIGHTH) begin
                next_ladder_taps = TAPS_STATIC;
            end else if (is_third) begin
                next_ladder_taps = TAPS_THIRD;
            end else if (bias == SLC_BIAS_HALF) begin
                next_ladder_taps = TAPS_HALF;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            backplane_line  <= '0;
            frontplane_line <= '0;
            backplane_oe    <= '0;
            frontplane_oe   <= '0;
            ladder_en       <= 1'b0;
            ladder_taps     <= TAPS_STATIC;
            contrast_tap    <= CONTRAST_FULL;
        end else begin
            backplane_line  <= next_backplane_line;
            frontplane_line <= next_frontplane_line;
            backplane_oe    <= next_backplane_oe;
            frontplane_oe   <= next_frontplane_oe;
            ladder_en       <= next_ladder_en;
            ladder_taps     <= next_ladder_taps;
            contrast_tap    <= next_contrast_tap;
        end
    end
endmodule
`default_nettype wire

// *** tb/slc_core_asserts.sv ***
// concurrent checks on the segment display controller ports
`timescale 1ns/1ps
`default_nettype none
module slc_core_asserts (
    // clock and reset
    input wire logic                       clk_sys,
    input wire logic                       nrst,
    // controls
    input wire logic                       enable,
    input wire logic [2:0]                 duty,
    input wire logic                       int_divider_sel,
    input wire logic                       frame_irq_en,
    input wire logic                       frame_flag_clr,
    input wire logic                       dma_sw_req,
    input wire logic                       dma_hw_en,
    input wire logic [slc_pkg::NUM_FP-1:0] fp_release,
    // watched outputs
    input wire logic [slc_pkg::NUM_FP-1:0] frontplane_oe,
    input wire logic                       ladder_en,
    input wire logic                       frame_flag,
    input wire logic                       dma_req,
    input wire logic                       frame_start
);
    import slc_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    a_sw_dma_next: assert property (dma_sw_req |=> dma_req)
        else $error("no dma request after software trigger");
    a_dma_cause: assert property (dma_req |->
        $past(dma_sw_req) || (frame_start && $past(dma_hw_en)))
        else $error("dma request without a cause");
    a_flag_sticky: assert property (frame_flag && !frame_flag_clr |=> frame_flag)
        else $error("frame flag dropped without clear");
    a_flag_clear: assert property (frame_flag_clr |=> !frame_flag || frame_start)
        else $error("frame flag survived clear");
    a_flag_cause: assert property ($rose(frame_flag) |-> frame_start && $past(frame_irq_en))
        else $error("frame flag set off a frame boundary");
    a_single_start: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    a_ladder_on: assert property ((enable && int_divider_sel)[*4] |-> ladder_en)
        else $error("internal divider not switched on");
    a_pin_release: assert property (
        (frontplane_oe & fp_release & $past(fp_release) & $past(fp_release, 2)) == '0)
        else $error("released pin still driven");
    a_eighth_lines: assert property ((duty == SLC_DUTY_EIGHTH)[*3] |->
        frontplane_oe[NUM_FP-1:36] == 4'h0)
        else $error("top frontplane lines driven at eighth duty");
endmodule
bind slc_core slc_core_asserts i_chk (
    .clk_sys, .nrst, .enable, .duty, .int_divider_sel, .frame_irq_en, .frame_flag_clr,
    .dma_sw_req, .dma_hw_en, .fp_release, .frontplane_oe, .ladder_en, .frame_flag, .dma_req,
    .frame_start
);
`default_nettype wire

// *** tb/slc_panel_model.sv ***
// passive panel model: integrates the voltage across every pixel
`timescale 1ns/1ps
`default_nettype none
module slc_panel_model (
    // panel pins
    input  wire logic                         clk_sys,
    input  wire logic [3*slc_pkg::NUM_BP-1:0] backplane_line,
    input  wire logic [3*slc_pkg::NUM_FP-1:0] frontplane_line,
    input  wire logic [slc_pkg::NUM_BP-1:0]   backplane_oe,
    input  wire logic [slc_pkg::NUM_FP-1:0]   frontplane_oe,
    // weighted net charge, constant across balanced frames
    output var  int                           dc_sig
);
    import slc_pkg::*;
    int acc [NUM_BP][NUM_FP];
    // charges only while both electrodes are driven
    always @(posedge clk_sys) begin
        int s;
        s = 0;
        for (int j = 0; j < NUM_BP; j++) begin
            for (int i = 0; i < NUM_FP; i++) begin
                if (backplane_oe[j] && frontplane_oe[i])
                    acc[j][i] += int'(backplane_line[3*j+:3]) - int'(frontplane_line[3*i+:3]);
                s += acc[j][i] * (j * NUM_FP + i + 1);
            end
        end
        dc_sig <= s;
    end
endmodule
`default_nettype wire

// *** tb/slc_core_tb.sv ***
// self-checking bench for the segment display controller
`timescale 1ns/1ps
`default_nettype none
module slc_core_tb;
    import slc_pkg::*;
    logic clk_sys = 1'h0, nrst = 1'h0, clk_src_sel = 1'h0, enable = 1'h0, layout = 1'h0;
    logic internal_slow_osc_tick = 1'h0, external_slow_crystal_tick = 1'h0;
    logic int_divider_sel = 1'h0, blink_en = 1'h0, frame_irq_en = 1'h0, store_wr = 1'h0;
    logic frame_flag_clr = 1'h0, dma_sw_req = 1'h0, dma_hw_en = 1'h0;
    logic [2:0] duty = 3'h0;
    logic [1:0] bias = 2'h0, blink_rate = 2'h0, ladder_taps;
    logic [3:0] contrast = 4'h0, frame_irq_count = 4'h0, store_addr = 4'h0, contrast_tap;
    logic [15:0] half_slot_ticks = '0;
    logic [31:0] store_wdata = '0, shadow [NUM_WORDS], act [NUM_WORDS];
    logic [NUM_FP-1:0] fp_release = '0, frontplane_oe;
    logic [NUM_BP-1:0] bp_release = '0, backplane_oe;
    logic [3*NUM_BP-1:0] backplane_line;
    logic [3*NUM_FP-1:0] frontplane_line;
    logic ladder_en, frame_flag, dma_req, frame_start;
    int n_mismatch, total_checks, cyc, fs_cyc, fs_len, tcnt, dc_sig;
    int lines [8] = '{1, 2, 3, 4, 6, 8, 1, 1};
    slc_core i_dut (
        .clk_sys, .nrst, .internal_slow_osc_tick, .external_slow_crystal_tick, .clk_src_sel,
        .enable, .duty, .bias, .layout, .int_divider_sel, .contrast, .half_slot_ticks,
        .blink_en, .blink_rate, .frame_irq_en, .frame_irq_count, .frame_flag_clr, .dma_sw_req,
        .dma_hw_en, .fp_release, .bp_release, .store_wr, .store_addr, .store_wdata,
        .backplane_line, .frontplane_line, .backplane_oe, .frontplane_oe, .ladder_en,
        .ladder_taps, .contrast_tap, .frame_flag, .dma_req, .frame_start
    );
    slc_panel_model i_panel (
        .clk_sys, .backplane_line, .frontplane_line, .backplane_oe, .frontplane_oe, .dc_sig
    );
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    // periodic ticks, equal half slots
    always @(negedge clk_sys) begin
        tcnt <= tcnt + 1;
        internal_slow_osc_tick <= (tcnt % 4 == 3);
        external_slow_crystal_tick <= (tcnt % 5 == 4);
    end
    task automatic chk(logic [119:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wcyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(int a, logic [31:0] d);
        store_wr = 1'h1;
        store_addr = 4'(a);
        store_wdata = d;
        shadow[a] = d;
        @(negedge clk_sys);
    endtask
    // wait for a frame start; shadow becomes shown
    task automatic wfs();
        int t = 0;
        do begin
            @(negedge clk_sys);
            t++;
        end while (frame_start !== 1'h1 && t < 3000);
        chk(t < 3000, 1'h1);
        fs_len = cyc - fs_cyc;
        fs_cyc = cyc;
        act = shadow;
    endtask
    function automatic logic pix(int i, ph);
        if (layout == 1'h0) return act[i / 4][8 * (i % 4) + ph];
        if (i < 32) return act[ph][i];
        return act[HI_WORD_BASE + ph][i - 32];
    endfunction
    function automatic logic [2:0] lvl(logic bp, hit, neg);
        logic [2:0] v;
        if (bp) v = hit ? LVL_TOP : (bias == SLC_BIAS_THIRD ? LVL_THIRD_LO : LVL_HALF);
        else v = hit ? LVL_GND : (bias == SLC_BIAS_THIRD ? LVL_THIRD_HI : LVL_TOP);
        return neg ? LVL_TOP - v : v;
    endfunction
    task automatic run_cfg(int d);
        int n, m, sig0, lag;
        logic [NUM_FP-1:0] fpm;
        enable = 1'h0;
        wcyc(3);
        n = lines[d];
        duty = 3'(d);
        bias = (n == 1) ? 2'($urandom_range(2)) : (n <= 3 ? SLC_BIAS_HALF : SLC_BIAS_THIRD);
        layout = (d == 5) ? 1'h1 : 1'($urandom);
        clk_src_sel = 1'($urandom);
        int_divider_sel = 1'($urandom);
        contrast = 4'($urandom);
        half_slot_ticks = 16'($urandom_range(2));
        fp_release = NUM_FP'({$urandom, $urandom} & {$urandom, $urandom});
        bp_release = 8'($urandom & $urandom & 32'hFE);
        for (int w = 0; w < NUM_WORDS; w++) wr(w, $urandom);
        store_wr = 1'h0;
        enable = 1'h1;
        m = (half_slot_ticks + 1) * (clk_src_sel ? 5 : 4);
        fpm = (d == 5) ? 40'h0FFFFFFFFF : '1;
        wfs();
        wfs();
        wcyc(1);
        sig0 = dc_sig;
        lag = 0;
        repeat (2) begin
            for (int k = 0; k < 2 * n; k++) begin
                wcyc((k == 0 ? m / 2 : m) - lag);
                lag = 0;
                for (int j = 0; j < n; j++)
                    if (!bp_release[j])
                        chk(backplane_line[3*j+:3], lvl(1'h1, j == k / 2, k[0]));
                for (int i = 0; i < NUM_FP; i++)
                    if (fpm[i] && !fp_release[i])
                        chk(frontplane_line[3*i+:3], lvl(1'h0, pix(i, k / 2), k[0]));
                if (k == 0) begin
                    chk(backplane_oe, 8'((1 << n) - 1) & ~bp_release);
                    chk(frontplane_oe, fpm & ~fp_release);
                    chk(ladder_en, int_divider_sel);
                    chk(contrast_tap, int_divider_sel ? contrast : 4'h0);
                    chk(ladder_taps, (!int_divider_sel || n == 1) ? TAPS_STATIC
                        : (bias == SLC_BIAS_THIRD ? TAPS_THIRD : TAPS_HALF));
                    // mid-frame write waits a frame
                    wr($urandom_range(15), $urandom);
                    store_wr = 1'h0;
                    lag = 1;
                end
            end
            wfs();
            chk(fs_len, 2 * n * m);
            wcyc(1);
            chk(dc_sig, sig0);
        end
        $display("end of scan test, duty code %0d", d);
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end
    initial begin
        int c, f, r, m, blanks;
        void'($urandom(32'h94CAEBA3));
        wcyc(2);
        chk({backplane_oe, frontplane_oe, ladder_en, frame_flag, dma_req, frame_start}, '0);
        wcyc(2);
        nrst = 1'h1;
        wcyc(2);
        for (int d = 0; d < 7; d++) run_cfg(d);
        enable = 1'h0;
        wcyc(3);
        duty = SLC_DUTY_HALF;
        bias = SLC_BIAS_HALF;
        layout = 1'h0;
        half_slot_ticks = 16'h0000;
        fp_release = '0;
        c = $urandom_range(3);
        frame_irq_count = 4'(c);
        frame_irq_en = 1'h1;
        dma_hw_en = 1'h1;
        frame_flag_clr = 1'h1;
        wr(0, 32'hFFFFFFFF);
        store_wr = 1'h0;
        frame_flag_clr = 1'h0;
        enable = 1'h1;
        m = clk_src_sel ? 5 : 4;
        f = 0;
        do begin
            wfs();
            f++;
            if (f > 1) chk(dma_req, 1'h1);
        end while (frame_flag !== 1'h1 && f < 20);
        chk(f, c + 2);
        frame_flag_clr = 1'h1;
        dma_hw_en = 1'h0;
        dma_sw_req = 1'h1;
        wcyc(1);
        frame_flag_clr = 1'h0;
        dma_sw_req = 1'h0;
        chk(frame_flag, 1'h0);
        chk(dma_req, 1'h1);
        f = 0;
        do begin
            wfs();
            f++;
            chk(dma_req, 1'h0);
        end while (frame_flag !== 1'h1 && f < 20);
        chk(f, c + 1);
        $display("end of event test");
        blink_rate = 2'($urandom);
        r = blink_rate;
        blink_en = 1'h1;
        wfs();
        blanks = 0;
        repeat (8 << r) begin
            wfs();
            wcyc(1 + m / 2);
            if (frontplane_line[2:0] !== LVL_GND) blanks++;
        end
        chk(blanks, 4 << r);
        $display("end of blink test");
        nrst = 1'h0;
        wcyc(1);
        chk({backplane_oe, frontplane_oe, frame_flag, frame_start}, '0);
        nrst = 1'h1;
        wcyc(2);
        $display("end of reset test");
        finish_test();
    end
endmodule
`default_nettype wire
